// ===== hw/uas_baud.sv
`timescale 1ns/1ps
module uas_baud
   import uas_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       ce,
   // control
   input  wire logic       run,
   input  wire logic [1:0] sel,
   input  wire logic [4:0] k,
   input  wire logic       ext_tick,
   // half bit strobe
   output logic            half_tick
);
   typedef struct packed {
      logic [4:0] pre;
      logic [4:0] div;
      logic [5:0] gap;
      logic       tick;
   } uas_baud_t;

   uas_baud_t  r, n;
   logic       base;
   logic [4:0] span, kk;

   // base clock choice
   always_comb begin
      case (sel)
         2'h0:    span = PRE_DIV2;
         2'h1:    span = PRE_DIV2;
         2'h2:    span = PRE_DIV8;
         default: span = PRE_DIV32;
      endcase
      base = (sel == 2'h0) ? ext_tick : (r.pre == span);
      kk   = (k < DIV_MIN) ? DIV_MIN : k;   // codes below 8 are prohibited
   end

   // 5-bit divider, its output is half a bit; gap keeps us under 625 kbps
   always_comb begin
      n      = r;
      n.tick = 1'b0;
      n.pre  = (r.pre == span) ? 5'h00 : r.pre + 5'h01;
      if (r.gap != 6'h3f) n.gap = r.gap + 6'h01;
      if (base) begin                                  // (R5)
         if (r.div >= kk - 5'h01) begin
            n.div = 5'h00;
            if (r.gap >= HALF_MIN_CYC - 6'h01) begin   // (R1)
               n.tick = 1'b1;
               n.gap  = 6'h00;
            end
         end else begin
            n.div = r.div + 5'h01;
         end
      end
      if (!run) n = '0;
   end

   assign half_tick = r.tick;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) r <= '0;
      else if (ce) r <= n;
   end
endmodule : uas_baud

// ===== hw/uas_fifo.sv
`timescale 1ns/1ps
module uas_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         ce,
   input  wire logic         flush,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } uas_fifo_t;

   uas_fifo_t r, n;
   logic      push, pop;

   // full and empty come straight from the count
   assign in_ready  = (r.cnt != (AW+1)'(D));
   assign out_valid = (r.cnt != '0);
   assign out_data  = r.mem[r.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // pointer and count update, flush drops everything
   always_comb begin
      n = r;
      if (push) begin
         n.mem[r.wp] = in_data;
         n.wp        = r.wp + 1'b1;
      end
      if (pop) n.rp = r.rp + 1'b1;
      n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (flush) begin
         n.wp  = '0;
         n.rp  = '0;
         n.cnt = '0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) r <= '0;
      else if (ce) r <= n;
   end
endmodule : uas_fifo

// ===== hw/uas_pkg.sv
package uas_pkg;

   // register addresses on the cpu port
   localparam logic [15:0] OFS_MODE  = 16'hff70;
   localparam logic [15:0] OFS_BAUD  = 16'hff71;
   localparam logic [15:0] OFS_DATA  = 16'hff72;
   localparam logic [15:0] OFS_ERR   = 16'hff73;

   // values after reset
   localparam logic [7:0]  RST_MODE  = 8'h01;
   localparam logic [7:0]  RST_BAUD  = 8'h1f;
   localparam logic [7:0]  RST_DATA  = 8'hff;
   localparam logic [7:0]  RST_ERR   = 8'h00;

   // serial_mode_control fields
   localparam int MODE_PWR  = 7;
   localparam int MODE_TXE  = 6;
   localparam int MODE_RXE  = 5;
   localparam int MODE_PSH  = 4;
   localparam int MODE_PSL  = 3;
   localparam int MODE_LEN  = 2;
   localparam int MODE_STOP = 1;

   // baud_divider_control fields and usable bits
   localparam int          BAUD_SELH = 7;
   localparam int          BAUD_SELL = 6;
   localparam logic [7:0]  BAUD_MASK = 8'hdf;
   localparam logic [4:0]  DIV_MIN   = 5'h08;

   // receive_error_status fields
   localparam int ERR_PAR  = 2;
   localparam int ERR_FRM  = 1;
   localparam int ERR_OVR  = 0;

   // parity select codes
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ZERO = 2'h1;
   localparam logic [1:0] PAR_ODD  = 2'h2;

   // base clock prescaler terminal counts, one less than the span in clk cycles
   localparam logic [4:0] PRE_DIV2  = 5'h01;
   localparam logic [4:0] PRE_DIV8  = 5'h07;
   localparam logic [4:0] PRE_DIV32 = 5'h1f;

   // timing: fastest legal bit time and its half, in cycles
   localparam int CLK_NS      = 25;
   localparam int BIT_MIN_NS  = 1600;
   localparam int BIT_MIN_CYC = (BIT_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [5:0] HALF_MIN_CYC = 6'(BIT_MIN_CYC / 2);

   // last data bit index for 7 and 8 bit characters
   localparam logic [2:0] LAST7 = 3'h6;
   localparam logic [2:0] LAST8 = 3'h7;

   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_WIDTH = 8;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uas_tx_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uas_rx_t;

   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] baud;
      logic [7:0] rbuf;
      logic [7:0] err;
      logic [7:0] rdata;
      logic       rx_full;
      logic [1:0] rx_sync;
      uas_tx_t    tx_st;
      logic       tx_ph;
      logic [2:0] tx_idx;
      logic       tx_stop2;
      logic       tx_line;
      logic       tx_par;
      logic [7:0] tx_shift;
      uas_rx_t    rx_st;
      logic       rx_ph;
      logic [2:0] rx_idx;
      logic [7:0] rx_shift;
      logic       rx_par;
      logic       tx_done;
      logic       rx_done;
      logic       rx_err;
   } uas_state_t;

   localparam uas_state_t RST_STATE = '{
      mode: RST_MODE, baud: RST_BAUD, rbuf: RST_DATA, err: RST_ERR,
      rdata: 8'h00, rx_full: 1'b0, rx_sync: 2'h3, tx_st: TX_IDLE,
      tx_ph: 1'b0, tx_idx: 3'h0, tx_stop2: 1'b0, tx_line: 1'b1,
      tx_par: 1'b0, tx_shift: RST_DATA, rx_st: RX_IDLE, rx_ph: 1'b0,
      rx_idx: 3'h0, rx_shift: RST_DATA, rx_par: 1'b0, tx_done: 1'b0,
      rx_done: 1'b0, rx_err: 1'b0};

endpackage : uas_pkg

// ===== hw/uas_top.sv
// Overview of operation
// (R1) serial rate never exceeds 625 kbps
// (R2) character length bit picks 7 or 8 data bits both ways
// (R3) data goes out and comes in lsb first only
// (R4) transmitter and receiver run independently at the same time
// (R5) a 5-bit divider counter makes bit timing from base clock
// (R6) each finished character is copied from shifter into receive buffer
// (R7) in 7-bit mode buffer bit 7 reads zero
// (R8) on overrun the new character is dropped and buffer kept
// (R9) receive buffer is read only, reset or power off sets ff
// (R10) writing a byte to the transmit shifter starts sending it
// (R11) transmit shifter write only, reset, power off or txe off sets ff
// (R12) software waits for transmit done before writing the next byte
// (R13) software waits one base clock after txe set before writing data
// (R14) software waits two base clocks before re-enabling txe or rxe
// (R15) power bit 7 cleared resets internal logic and error status
// (R16) while power is off the serial input reads high
// (R17) transmit enable bit 6 cleared resets transmitter, set enables it
// (R18) receive enable bit 5 cleared resets receiver, set enables it
// (R19) software sets power before transmit or receive enable
// (R20) parity field bits 4:3: none, zero, odd, even; only odd and even are checked on receive
// (R21) stop select 0 sends one stop bit
// (R22) stopped clock freezes registers and output pin
// (R23) stop select 1 sends two stop bits
// (R24) zero parity mode never flags a receive parity error
// (R25) receiver always uses one stop bit
// (R26) bit rate is divider output divided by two
// (R27) frames start low, end high, line idles high
`timescale 1ns/1ps
module uas_top
   import uas_pkg::*;
(
   // clock, reset, enable
   input  wire logic        CLK,
   input  wire logic        RESETN,
   input  wire logic        CE,
   // cpu register port
   input  wire logic [15:0] ADDR,
   input  wire logic        WR,
   input  wire logic        RD,
   input  wire logic [7:0]  WDATA,
   output logic      [7:0]  RDATA,
   output logic             TX_READY,
   // base clock from a timer
   input  wire logic        EXT_BASE_TICK,
   // serial pins
   input  wire logic        SERIAL_IN_PIN,
   output logic             SERIAL_OUT_PIN,
   // events
   output logic             TX_DONE,
   output logic             RX_DONE,
   output logic             RX_ERROR
);

   ////////////////////////////////////////////////////////////////////////////

   uas_state_t r, n;

   logic       pwr, txe, rxe, len8;
   logic [1:0] psel;
   logic       half_tick;
   logic       rx_in;
   logic       fifo_in_valid;
   logic       fifo_out_valid;
   logic       fifo_out_ready;
   logic [7:0] fifo_out_data;
   logic       fifo_flush;
   logic [2:0] last_idx;
   logic [7:0] rx_word;

   // parity bit for a character under the selected mode
   function automatic logic par_of(input logic [7:0] d, input logic [1:0] ps);
      logic p;
      p = 1'b0;
      if (ps == PAR_ODD) p = ~^d;
      else if (ps != PAR_ZERO && ps != PAR_NONE) p = ^d;
      return p;
   endfunction : par_of

   // decoded mode bits
   assign pwr      = r.mode[MODE_PWR];
   assign txe      = r.mode[MODE_TXE] && pwr;
   assign rxe      = r.mode[MODE_RXE] && pwr;
   assign len8     = r.mode[MODE_LEN];                // (R2)
   assign psel     = {r.mode[MODE_PSH], r.mode[MODE_PSL]};
   assign last_idx = len8 ? LAST8 : LAST7;

   // power off pins the input high so no false start is seen
   assign rx_in = pwr ? r.rx_sync[1] : 1'b1;         // (R16)

   // 7-bit characters arrive in the top seven bits of the shifter
   assign rx_word = len8 ? r.rx_shift : {1'b0, r.rx_shift[7:1]};  // (R7)

   ////////////////////////////////////////////////////////////////////////////

   // half bit strobe shared by both directions
   uas_baud u_baud (
      .clk       (CLK),
      .rstn      (RESETN),
      .ce        (CE),
      .run       (pwr),
      .sel       ({r.baud[BAUD_SELH], r.baud[BAUD_SELL]}),
      .k         (r.baud[4:0]),
      .ext_tick  (EXT_BASE_TICK),
      .half_tick (half_tick)
   );

   // data writes queue up; ready drops once sixteen are waiting
   assign fifo_in_valid  = WR && (ADDR == OFS_DATA) && txe;
   assign fifo_out_ready = txe && (r.tx_st == TX_IDLE) && half_tick;  // (R1)
   assign fifo_flush     = !txe;                       // (R11)

   uas_fifo #(
      .W (FIFO_WIDTH),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clk       (CLK),
      .rstn      (RESETN),
      .ce        (CE),
      .flush     (fifo_flush),
      .in_valid  (fifo_in_valid),
      .in_ready  (TX_READY),
      .in_data   (WDATA),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   ////////////////////////////////////////////////////////////////////////////

   // next state: registers, transmitter, receiver, then enable resets
   always_comb begin
      n         = r;
      n.tx_done = 1'b0;
      n.rx_done = 1'b0;
      n.rx_err  = 1'b0;
      n.rx_sync = {r.rx_sync[0], SERIAL_IN_PIN};

      // cpu writes; bit 0 of mode always reads one
      if (WR) begin
         case (ADDR)
            OFS_MODE: n.mode = {WDATA[7:1], 1'b1};
            OFS_BAUD: n.baud = WDATA & BAUD_MASK;
            default:  ;                               // (R9)
         endcase
      end

      // cpu reads; unmapped addresses give zero, the data address returns the receive buffer
      if (RD) begin
         case (ADDR)
            OFS_MODE: n.rdata = r.mode;
            OFS_BAUD: n.rdata = r.baud;
            OFS_DATA: n.rdata = r.rbuf;
            OFS_ERR:  n.rdata = r.err;
            default:  n.rdata = 8'h00;
         endcase
         if (ADDR == OFS_ERR) n.err = RST_ERR;
         if (ADDR == OFS_DATA) n.rx_full = 1'b0;
      end

      // transmitter: load from the queue when idle
      if (fifo_out_ready && fifo_out_valid) begin     // (R10)
         n.tx_shift = fifo_out_data;
         n.tx_par   = par_of(fifo_out_data & (len8 ? 8'hff : 8'h7f), psel);
         n.tx_st    = TX_START;
         n.tx_ph    = 1'b0;
         n.tx_line  = 1'b0;                           // (R27)
      end else if (half_tick && r.tx_st != TX_IDLE) begin
         n.tx_ph = !r.tx_ph;
         // every bit lasts two half ticks
         if (r.tx_ph) begin                           // (R26)
            case (r.tx_st)
               TX_START: begin
                  n.tx_st   = TX_DATA;
                  n.tx_idx  = 3'h0;
                  n.tx_line = r.tx_shift[0];          // (R3)
               end
               TX_DATA: begin
                  n.tx_shift = {1'b1, r.tx_shift[7:1]};
                  n.tx_idx   = r.tx_idx + 3'h1;
                  if (r.tx_idx == last_idx) begin
                     n.tx_stop2 = r.mode[MODE_STOP];  // (R21) (R23)
                     if (psel != PAR_NONE) begin      // (R20)
                        n.tx_st   = TX_PAR;
                        n.tx_line = r.tx_par;
                     end else begin
                        n.tx_st   = TX_STOP;
                        n.tx_line = 1'b1;
                     end
                  end else begin
                     n.tx_line = r.tx_shift[1];
                  end
               end
               TX_PAR: begin
                  n.tx_st   = TX_STOP;
                  n.tx_line = 1'b1;
               end
               TX_STOP: begin
                  if (r.tx_stop2) begin
                     n.tx_stop2 = 1'b0;               // (R23)
                  end else begin
                     n.tx_st   = TX_IDLE;
                     n.tx_done = 1'b1;
                  end
               end
               default: n.tx_st = TX_IDLE;
            endcase
         end
      end

      // receiver: look for a low start bit, then sample every two half ticks after the start check
      case (r.rx_st)
         RX_IDLE: begin
            if (rxe && !rx_in) begin
               n.rx_st = RX_START;
               n.rx_ph = 1'b0;
            end
         end
         RX_START: begin
            // at the next half tick: a glitch that went high is ignored
            if (half_tick) begin
               n.rx_st  = rx_in ? RX_IDLE : RX_DATA;
               n.rx_ph  = 1'b0;
               n.rx_idx = 3'h0;
            end
         end
         RX_DATA: begin
            if (half_tick) begin
               n.rx_ph = !r.rx_ph;
               if (r.rx_ph) begin
                  n.rx_shift = {rx_in, r.rx_shift[7:1]};  // (R3)
                  n.rx_idx   = r.rx_idx + 3'h1;
                  if (r.rx_idx == last_idx) begin        // (R2)
                     n.rx_st = (psel != PAR_NONE) ? RX_PAR : RX_STOP;
                  end
               end
            end
         end
         RX_PAR: begin
            if (half_tick) begin
               n.rx_ph = !r.rx_ph;
               if (r.rx_ph) begin
                  n.rx_par = rx_in;
                  n.rx_st  = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            // only the first stop bit is looked at
            if (half_tick) begin
               n.rx_ph = !r.rx_ph;
               if (r.rx_ph) begin                     // (R25)
                  n.rx_st   = RX_IDLE;
                  n.rx_done = 1'b1;
                  // setting a flag wins over a same-cycle read clear
                  if (!rx_in) n.err[ERR_FRM] = 1'b1;
                  if (psel[1] && r.rx_par != par_of(rx_word, psel)) begin  // (R24)
                     n.err[ERR_PAR] = 1'b1;           // (R20)
                  end
                  if (r.rx_full && !(RD && ADDR == OFS_DATA)) begin
                     n.err[ERR_OVR] = 1'b1;           // (R8)
                  end else begin
                     n.rbuf    = rx_word;             // (R6)
                     n.rx_full = 1'b1;
                  end
                  n.rx_err = !rx_in || (r.rx_full && !(RD && ADDR == OFS_DATA))
                             || (psel[1] && r.rx_par != par_of(rx_word, psel));
               end
            end
         end
         default: n.rx_st = RX_IDLE;
      endcase

      // transmit enable low: idle line, shifter back to ones
      if (!txe) begin                                 // (R17)
         n.tx_st    = TX_IDLE;
         n.tx_ph    = 1'b0;
         n.tx_stop2 = 1'b0;
         n.tx_line  = 1'b1;
         n.tx_shift = RST_DATA;                       // (R11)
         n.tx_done  = 1'b0;
      end

      // receive enable low: receiver idle, parity and framing cleared
      if (!rxe) begin                                 // (R18)
         n.rx_st        = RX_IDLE;
         n.rx_ph        = 1'b0;
         n.err[ERR_PAR] = 1'b0;
         n.err[ERR_FRM] = 1'b0;
         n.rx_done      = 1'b0;
         n.rx_err       = 1'b0;
      end

      // power off: receive buffer, its full flag, error status and receive shifter back to reset
      if (!pwr) begin                                 // (R15)
         n.rbuf    = RST_DATA;                        // (R9)
         n.err     = RST_ERR;
         n.rx_full = 1'b0;
         n.rx_shift = RST_DATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   // one register bank; ce low freezes the whole unit and the pin
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) r <= RST_STATE;
      else if (CE) r <= n;                            // (R22)
   end

   // outputs straight from flops
   assign RDATA          = r.rdata;
   assign SERIAL_OUT_PIN = r.tx_line;                 // (R27)
   assign TX_DONE        = r.tx_done;                 // (R4)
   assign RX_DONE        = r.rx_done;
   assign RX_ERROR       = r.rx_err;

endmodule : uas_top

// ===== tb/uas_props.sv
`timescale 1ns/1ps
module uas_props
   import uas_pkg::*;
(
   // clock, reset, enable
   input wire logic        CLK,
   input wire logic        RESETN,
   input wire logic        CE,
   // cpu register port
   input wire logic [15:0] ADDR,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [7:0]  WDATA,
   input wire logic [7:0]  RDATA,
   input wire logic        TX_READY,
   // base tick and serial pins
   input wire logic        EXT_BASE_TICK,
   input wire logic        SERIAL_IN_PIN,
   input wire logic        SERIAL_OUT_PIN,
   // events
   input wire logic        TX_DONE,
   input wire logic        RX_DONE,
   input wire logic        RX_ERROR
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);

   ////////////////////////////////////////////////////////////////////////////////
   logic [9:0] lo_r;
   logic [9:0] hi_r;

   // saturating run lengths of the output line
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         lo_r <= 10'h0;
         hi_r <= 10'h0;
      end else if (CE) begin
         lo_r <= SERIAL_OUT_PIN ? 10'h0 : lo_r + {9'h0, ~&lo_r};
         hi_r <= SERIAL_OUT_PIN ? hi_r + {9'h0, ~&hi_r} : 10'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   AST_IDLE_AFTER_RESET: assert property ($rose(RESETN) |-> SERIAL_OUT_PIN)
      else $error("line not idle after reset");
   AST_LOW_RUN_MIN: assert property ($rose(SERIAL_OUT_PIN) |-> lo_r >= 10'd63)
      else $error("low run under a bit");
   AST_STOP_BEFORE_DONE: assert property (TX_DONE |-> hi_r >= 10'd60)
      else $error("done before full stop bit");
   AST_TX_DONE_PULSE: assert property (TX_DONE |=> !TX_DONE)
      else $error("tx done too long");
   AST_IDLE_AFTER_DONE: assert property (TX_DONE |=> SERIAL_OUT_PIN)
      else $error("line not high after a frame");
   AST_RX_DONE_PULSE: assert property (RX_DONE |=> !RX_DONE)
      else $error("rx done too long");
   AST_ERR_WITH_DONE: assert property (RX_ERROR |-> RX_DONE)
      else $error("error without rx done");
   AST_RDATA_HOLD: assert property (!RD |=> $stable(RDATA))
      else $error("rdata moved without read");

   // main scenarios reached
   COV_TX: cover property (TX_DONE);
   COV_RX_OK: cover property (RX_DONE && !RX_ERROR);
   COV_RX_ERR: cover property (RX_ERROR);
endmodule : uas_props

// ===== tb/uas_remote.sv
`timescale 1ns/1ps
module uas_remote #(
   parameter int BIT = 64
) (
   // clock
   input  wire logic clk,
   // serial wires
   input  wire logic line_in,
   output logic      line_out
);
   logic [11:0] cap = 12'hfff;
   int          nbits = 10;
   int          frames = 0;

   // the far line idles high between frames
   initial line_out = 1'b1;

   // start bit, then n bits lsb first
   task automatic send(input logic [11:0] bits, input int n);
      line_out <= 1'b0;
      repeat (BIT) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         line_out <= bits[i];
         repeat (BIT) @(posedge clk);
      end
      line_out <= 1'b1;
   endtask : send

   // mid-bit capture, stops included
   always begin
      @(negedge line_in);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < nbits; i++) begin
         repeat (BIT) @(posedge clk);
         cap[i] = line_in;
      end
      frames++;
   end
endmodule : uas_remote

// ===== tb/uas_top_tb.sv
`timescale 1ns/1ps
module uas_top_tb;
   import uas_pkg::*;
   localparam int BIT = 64;
   logic        CLK = 1'b0;
   logic        RESETN = 1'b0;
   logic        CE = 1'b1;
   logic        WR = 1'b0;
   logic        RD = 1'b0;
   logic        EXT_BASE_TICK = 1'b0;
   logic [15:0] ADDR = 16'h0;
   logic [7:0]  WDATA = 8'h0;
   logic [7:0]  RDATA;
   logic        TX_READY, SERIAL_IN_PIN, SERIAL_OUT_PIN, TX_DONE, RX_DONE, RX_ERROR;
   int          fails = 0;
   int          n_tests = 0;

   // 40 MHz clock, free base tick
   always #12.5 CLK = ~CLK;
   always @(posedge CLK) EXT_BASE_TICK <= ~EXT_BASE_TICK;

   uas_top uas_top_inst (.*);
   uas_remote #(.BIT(BIT)) uas_remote_inst (.clk(CLK), .line_in(SERIAL_OUT_PIN),
      .line_out(SERIAL_IN_PIN));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8

   task automatic chkf(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t frame got=%h exp=%h", $time, got, exp);
      end
   endtask : chkf

   // trailing edge avoids a double strobe
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
      @(posedge CLK);
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 d = RDATA;
      @(posedge CLK);
   endtask : rd

   // bounded wait for a done pulse
   task automatic wait_ev(output logic err, input logic is_rx);
      int i;
      for (i = 0; i < 2000; i++) begin
         @(posedge CLK);
         #1;
         if (is_rx ? RX_DONE === 1'b1 : TX_DONE === 1'b1) break;
      end
      err = RX_ERROR;
      if (i == 2000) begin
         chk8(8'h00, 8'h01);
         report_and_stop();
      end
      @(posedge CLK);
   endtask : wait_ev

   // expected bits after start, ones above
   function automatic logic [11:0] frame(input logic [7:0] m, input logic [7:0] d);
      logic [11:0] f;
      logic        p;
      int          n;
      n = m[MODE_LEN] ? 8 : 7;
      f = m[MODE_LEN] ? {4'hf, d} : {5'h1f, d[6:0]};
      p = m[MODE_LEN] ? ^d : ^d[6:0];
      if (m[MODE_PSH:MODE_PSL] != PAR_NONE)
         f[n] = (m[MODE_PSH:MODE_PSL] == PAR_ZERO) ? 1'b0 : (m[MODE_PSH] & ~m[MODE_PSL]) ^ p;
      return f;
   endfunction : frame

   function automatic int flen(input logic [7:0] m);
      return (m[MODE_LEN] ? 8 : 7) + (m[MODE_PSH:MODE_PSL] != PAR_NONE ? 1 : 0) +
         (m[MODE_STOP] ? 2 : 1);
   endfunction : flen

   // both directions off, then spaced re-enable
   task automatic set_mode(input logic [7:0] m);
      wr(OFS_MODE, 8'h81);
      repeat (8) @(posedge CLK);
      wr(OFS_MODE, m);
      repeat (4) @(posedge CLK);
   endtask : set_mode

   task automatic rx_one(input logic [7:0] m, input logic [11:0] f, input logic [7:0] d,
                         input logic [7:0] eerr);
      logic       e;
      logic [7:0] v;
      set_mode(m);
      fork
         uas_remote_inst.send(f, flen(m));
         wait_ev(e, 1'b1);
      join
      chk8({7'h0, e}, {7'h0, |eerr});
      rd(OFS_ERR, v);
      chk8(v, eerr);
      rd(OFS_DATA, v);
      chk8(v, d);
   endtask : rx_one

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [7:0]  v;
      logic [15:0] a [5] = '{OFS_MODE, OFS_BAUD, OFS_DATA, OFS_ERR, 16'hff74};
      logic [7:0]  e [5] = '{RST_MODE, RST_BAUD, RST_DATA, RST_ERR, 8'h00};
      wr(OFS_DATA, 8'h55);
      for (int i = 0; i < 5; i++) begin
         rd(a[i], v);
         chk8(v, e[i]);
      end
      chk8({7'h0, TX_READY}, 8'h01);
   endtask : t_reset

   // all parity codes, lengths, stop counts, full duplex
   task automatic t_duplex();
      logic [7:0] m [4] = '{8'he5, 8'heb, 8'hf5, 8'hfb};
      logic [7:0] d [4] = '{8'h5a, 8'hc3, 8'h81, 8'h7e};
      logic       et, er;
      logic [7:0] v;
      for (int i = 0; i < 4; i++) begin
         set_mode(m[i]);
         uas_remote_inst.nbits = flen(m[i]);
         uas_remote_inst.cap = 12'hfff;
         fork
            begin
               wr(OFS_DATA, d[i]);
               wait_ev(et, 1'b0);
            end
            uas_remote_inst.send(frame(m[i], ~d[i]), flen(m[i]));
            wait_ev(er, 1'b1);
         join
         chkf(uas_remote_inst.cap, frame(m[i], d[i]));
         chk8({7'h0, er}, 8'h00);
         rd(OFS_ERR, v);
         chk8(v, 8'h00);
         rd(OFS_DATA, v);
         chk8(v, m[i][MODE_LEN] ? ~d[i] : {1'b0, ~d[i][6:0]});
      end
   endtask : t_duplex

   task automatic t_rx_errors();
      rx_one(8'hf5, frame(8'hf5, 8'h96) ^ 12'h100, 8'h96, 8'h04);
      rx_one(8'hed, frame(8'hed, 8'h96) | 12'h100, 8'h96, 8'h00);
      rx_one(8'hf5, frame(8'hf5, 8'h96) ^ 12'h200, 8'h96, 8'h02);
   endtask : t_rx_errors

   // back-to-back single-stop frames
   task automatic t_overrun();
      logic       e;
      logic [7:0] v;
      set_mode(8'he7);
      fork
         begin
            uas_remote_inst.send(frame(8'he5, 8'h11), 9);
            uas_remote_inst.send(frame(8'he5, 8'h22), 9);
         end
         begin
            wait_ev(e, 1'b1);
            wait_ev(e, 1'b1);
         end
      join
      chk8({7'h0, e}, 8'h01);
      rd(OFS_ERR, v);
      chk8(v, 8'h01);
      rd(OFS_DATA, v);
      chk8(v, 8'h11);
      wr(OFS_MODE, 8'h01);
      rd(OFS_DATA, v);
      chk8(v, RST_DATA);
   endtask : t_overrun

   // bytes written with txe off never leave
   task automatic t_tx_gate();
      logic e;
      int   f0;
      wr(OFS_MODE, 8'h81);
      wr(OFS_DATA, 8'h3c);
      f0 = uas_remote_inst.frames;
      set_mode(8'he5);
      repeat (3 * BIT) @(posedge CLK);
      chk8(8'(uas_remote_inst.frames - f0), 8'h00);
      uas_remote_inst.nbits = 9;
      wr(OFS_DATA, 8'h0f);
      wr(OFS_DATA, 8'hf0);
      wait_ev(e, 1'b0);
      wait_ev(e, 1'b0);
      chk8(8'(uas_remote_inst.frames - f0), 8'h02);
      chkf(uas_remote_inst.cap, 12'hff0);
   endtask : t_tx_gate

   ////////////////////////////////////////////////////////////////////////////////
   // reset, then clk/2 base, k=8: fastest rate
   initial begin
      repeat (20) @(posedge CLK);
      RESETN <= 1'b1;
      @(posedge CLK);
      t_reset();
      wr(OFS_MODE, 8'h81);
      wr(OFS_BAUD, 8'h48);
      t_duplex();
      t_rx_errors();
      t_overrun();
      t_tx_gate();
      report_and_stop();
   end
endmodule : uas_top_tb

bind uas_top uas_props uas_props_inst (.*);
